// ==== common/dmi_defs.svh ====
// register map, reset values and timing counts of the digital mic input
// assumes: included by its bare name from package and design files
`ifndef DMI_DEFS_SVH
`define DMI_DEFS_SVH
`define DMI_OFS_TASK_START 12'h000
`define DMI_OFS_TASK_STOP 12'h004
`define DMI_OFS_EV_STARTED 12'h100
`define DMI_OFS_EV_STOPPED 12'h104
`define DMI_OFS_EV_END 12'h108
`define DMI_OFS_ENABLE 12'h500
`define DMI_OFS_CLKCTRL 12'h504
`define DMI_OFS_MODE 12'h508
`define DMI_OFS_LEFT_GAIN_ADJUST 12'h518
`define DMI_OFS_RIGHT_GAIN_ADJUST 12'h51c
`define DMI_OFS_PTR 12'h560
`define DMI_OFS_MAXCNT 12'h564
`define DMI_BIT_CLOCK_DIVIDER_SELECT_DIV32 32'h08000000
`define DMI_BIT_CLOCK_DIVIDER_SELECT_DIV31 32'h08400000
`define DMI_BIT_CLOCK_DIVIDER_SELECT_DIV30 32'h08800000
`define DMI_CLKCTRL_RST 32'h08400000
`define DMI_GAIN_FLOOR 7'h00
`define DMI_GAIN_ZERO_DB 7'h28
`define DMI_GAIN_CEIL 7'h50
`define DMI_MODE_OP_BIT 0
`define DMI_MODE_EDGE_BIT 1
`define DMI_DECIM 7'h40
`define DMI_MAXCNT_W 15
`endif

// ==== common/dmi_pkg.sv ====
// types shared by the digital mic input
// assumes: nothing beyond the defs header
`include "dmi_defs.svh"
`default_nettype none
package dmi_pkg;
  typedef enum logic [1:0] {
    DMI_IDLE = 2'b00,
    DMI_RUN = 2'b01,
    DMI_DRAIN = 2'b11
  } dmi_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } dmi_dma_word_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] ofs;
  } dmi_ahb_req_t;
endpackage : dmi_pkg
`default_nettype wire

// ==== rtl/dmi_top.sv ====
// digital mic input: bit clock, decimators, gain, packing, dma writer, ahb-lite regs
// assumes: one 200 MHz clock, mic data synchronous to it, one ahb-lite master
//
// Summary of operation
// - bit clock divided from system clock
// - default: left on falling, right rising
// - edge select swaps left and right
// - decimate by 64 into 16-bit pcm
// - per-channel gain, 0.5 dB steps
// - stereo L+R per word, mono two lefts
// - earlier sample low half, later high
// - buffer size counts 16-bit samples
// - pointer and size before start task
// - stop finishes current frame first
// - stopped only after all writes done
// - buffer pointer is double-buffered
// - end event when buffer full
// - after end continue at latched pointer
// - divider 32, 31, 30 by field code
// - gain codes 0x00, 0x28, 0x50
`include "dmi_defs.svh"
`default_nettype none

module dmi_chan import dmi_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clr,
  input wire logic i_bit_en,
  input wire logic i_bit,
  input wire logic [6:0] i_gain,
  output logic o_valid,
  output logic [15:0] o_pcm
);
  logic [5:0] phase_reg;
  logic [6:0] ones_reg;
  logic [6:0] ones_next;
  logic signed [16:0] raw;
  logic [6:0] gsat;
  logic [6:0] gidx;
  logic [2:0] gq;
  logic [3:0] gr;
  logic [15:0] gtab;
  logic signed [32:0] prod;
  logic signed [32:0] scaled;
  logic [5:0] bits_seen;

  assign ones_next = ones_reg + {6'h00, i_bit};
  // boxcar of 64 bits, centred on half density
  always_comb begin
    raw = 17'(($signed({10'h000, ones_next}) - 17'sd32) <<< 10);
    if (ones_next == `DMI_DECIM) begin
      raw = 17'sh07fff;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_reg <= 6'h00;
      ones_reg <= 7'h00;
    end else if (i_clr) begin
      phase_reg <= 6'h00;
      ones_reg <= 7'h00;
    end else if (i_bit_en) begin
      phase_reg <= phase_reg + 6'h01;
      ones_reg <= (phase_reg == 6'h3f) ? 7'h00 : ones_next;
    end
  end

  // factor = 2^(q-4) * 10^(r/40), idx = code + 8 = 12q + r
  assign gsat = (i_gain > `DMI_GAIN_CEIL) ? `DMI_GAIN_CEIL : i_gain;
  assign gidx = gsat + 7'h08;
  assign gq = 3'(gidx / 7'd12);
  assign gr = 4'(gidx % 7'd12);
  always_comb begin
    unique case (gr)
      4'h0: gtab = 16'h4000;
      4'h1: gtab = 16'h43cb;
      4'h2: gtab = 16'h47cf;
      4'h3: gtab = 16'h4c10;
      4'h4: gtab = 16'h5092;
      4'h5: gtab = 16'h5558;
      4'h6: gtab = 16'h5a67;
      4'h7: gtab = 16'h5fc2;
      4'h8: gtab = 16'h656f;
      4'h9: gtab = 16'h6b72;
      4'ha: gtab = 16'h71d0;
      4'hb: gtab = 16'h788e;
      default: gtab = 16'h4000;
    endcase
  end
  assign prod = 33'($signed(raw[15:0]) * $signed({1'b0, gtab}));
  assign scaled = prod >>> (5'd18 - {2'b00, gq});

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_pcm <= 16'h0000;
    end else begin
      o_valid <= i_bit_en && (phase_reg == 6'h3f) && !i_clr;
      if (i_bit_en && (phase_reg == 6'h3f)) begin
        if (scaled > 33'sh07fff) begin
          o_pcm <= 16'h7fff;
        end else if (scaled < -33'sh08000) begin
          o_pcm <= 16'h8000;
        end else begin
          o_pcm <= scaled[15:0];
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bits_seen <= 6'h00;
    end else if (i_clr || o_valid) begin
      bits_seen <= {5'h00, i_bit_en && !i_clr};
    end else if (i_bit_en) begin
      bits_seen <= bits_seen + 6'h01;
    end
  end
  decim_rate_a: assert property (o_valid |-> $past(bits_seen) == 6'h3f)
    else $error("decimator output not after 64 bits");
  unity_gain_a: assert property (
    i_bit_en && phase_reg == 6'h3f && !i_clr && i_gain == `DMI_GAIN_ZERO_DB
    |=> o_pcm[15:1] == $past(raw[15:1]) || o_pcm == 16'h7fff)
    else $error("zero dB code does not pass samples unchanged");
endmodule : dmi_chan

module dmi_top import dmi_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_mic_bit_clock,
  input wire logic i_mic_data,
  output logic o_dma_valid,
  output dmi_dma_word_t o_dma_word,
  input wire logic i_dma_ready
);
  dmi_ahb_req_t req_reg;
  dmi_state_t state_reg;
  logic enable_reg;
  logic [31:0] clkctrl_reg;
  logic mono_reg;
  logic edge_reg;
  logic [6:0] left_gain_adjust_reg;
  logic [6:0] right_gain_adjust_reg;
  logic [31:0] ptr_reg;
  logic [`DMI_MAXCNT_W-1:0] maxcnt_reg;
  logic ev_started_reg;
  logic ev_stopped_reg;
  logic ev_end_reg;
  logic [5:0] div;
  logic [5:0] bclk_cnt_reg;
  logic running;
  logic rise_en;
  logic fall_en;
  logic l_en;
  logic r_en;
  logic chan_clr;
  logic l_valid;
  logic r_valid;
  logic [15:0] l_pcm;
  logic [15:0] r_pcm;
  logic half_reg;
  logic [15:0] held_reg;
  logic word_rdy;
  logic [31:0] word;
  logic [31:0] wr_addr_reg;
  logic [`DMI_MAXCNT_W:0] samples_reg;
  logic dma_done;
  logic buf_full;
  logic start_task;
  logic stop_task;
  logic started_set;
  logic stopped_set;
  logic end_set;
  logic wr;

  // ahb-lite slave: zero wait states, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign wr = req_reg.valid && req_reg.write;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_reg <= '0;
    end else if (i_hready) begin
      req_reg.valid <= i_hsel && i_htrans[1] && (i_hsize == 3'h2);
      req_reg.write <= i_hwrite;
      req_reg.ofs <= {i_haddr[11:2], 2'b00};
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h00000000;
    end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      unique case ({i_haddr[11:2], 2'b00})
        `DMI_OFS_EV_STARTED: o_hrdata <= {31'h0, ev_started_reg};
        `DMI_OFS_EV_STOPPED: o_hrdata <= {31'h0, ev_stopped_reg};
        `DMI_OFS_EV_END: o_hrdata <= {31'h0, ev_end_reg};
        `DMI_OFS_ENABLE: o_hrdata <= {31'h0, enable_reg};
        `DMI_OFS_CLKCTRL: o_hrdata <= clkctrl_reg;
        `DMI_OFS_MODE: o_hrdata <= {30'h0, edge_reg, mono_reg};
        `DMI_OFS_LEFT_GAIN_ADJUST: o_hrdata <= {25'h0, left_gain_adjust_reg};
        `DMI_OFS_RIGHT_GAIN_ADJUST: o_hrdata <= {25'h0, right_gain_adjust_reg};
        `DMI_OFS_PTR: o_hrdata <= ptr_reg;
        `DMI_OFS_MAXCNT: o_hrdata <= {{(32-`DMI_MAXCNT_W){1'b0}}, maxcnt_reg};
        default: o_hrdata <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      enable_reg <= 1'b0;
      clkctrl_reg <= `DMI_CLKCTRL_RST;
      mono_reg <= 1'b0;
      edge_reg <= 1'b0;
      left_gain_adjust_reg <= `DMI_GAIN_ZERO_DB;
      right_gain_adjust_reg <= `DMI_GAIN_ZERO_DB;
      ptr_reg <= 32'h00000000;
      maxcnt_reg <= '0;
    end else if (wr) begin
      unique case (req_reg.ofs)
        `DMI_OFS_ENABLE: enable_reg <= i_hwdata[0];
        `DMI_OFS_CLKCTRL: clkctrl_reg <= i_hwdata;
        `DMI_OFS_MODE: begin
          mono_reg <= i_hwdata[`DMI_MODE_OP_BIT];
          edge_reg <= i_hwdata[`DMI_MODE_EDGE_BIT];
        end
        `DMI_OFS_LEFT_GAIN_ADJUST: left_gain_adjust_reg <= i_hwdata[6:0];
        `DMI_OFS_RIGHT_GAIN_ADJUST: right_gain_adjust_reg <= i_hwdata[6:0];
        `DMI_OFS_PTR: ptr_reg <= i_hwdata;
        `DMI_OFS_MAXCNT: maxcnt_reg <= i_hwdata[`DMI_MAXCNT_W-1:0];
        default: ;
      endcase
    end
  end
  assign start_task = wr && req_reg.ofs == `DMI_OFS_TASK_START && i_hwdata[0];
  assign stop_task = wr && req_reg.ofs == `DMI_OFS_TASK_STOP && i_hwdata[0];

  // sticky events: a hardware set beats a software clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ev_started_reg <= 1'b0;
      ev_stopped_reg <= 1'b0;
      ev_end_reg <= 1'b0;
    end else begin
      if (started_set) begin
        ev_started_reg <= 1'b1;
      end else if (wr && req_reg.ofs == `DMI_OFS_EV_STARTED && !i_hwdata[0]) begin
        ev_started_reg <= 1'b0;
      end
      if (stopped_set) begin
        ev_stopped_reg <= 1'b1;
      end else if (wr && req_reg.ofs == `DMI_OFS_EV_STOPPED && !i_hwdata[0]) begin
        ev_stopped_reg <= 1'b0;
      end
      if (end_set) begin
        ev_end_reg <= 1'b1;
      end else if (wr && req_reg.ofs == `DMI_OFS_EV_END && !i_hwdata[0]) begin
        ev_end_reg <= 1'b0;
      end
    end
  end

  // bit clock: period of div system cycles, high for the first half
  always_comb begin
    unique case (clkctrl_reg)
      `DMI_BIT_CLOCK_DIVIDER_SELECT_DIV32: div = 6'd32;
      `DMI_BIT_CLOCK_DIVIDER_SELECT_DIV30: div = 6'd30;
      default: div = 6'd31;
    endcase
  end
  assign running = state_reg != DMI_IDLE;
  assign rise_en = running && bclk_cnt_reg >= div - 6'd1;
  // no falling edge, and no left sample, before the first rise
  assign fall_en = running && o_mic_bit_clock && bclk_cnt_reg == (div >> 1) - 6'd1;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bclk_cnt_reg <= 6'h00;
      o_mic_bit_clock <= 1'b0;
    end else if (!running) begin
      bclk_cnt_reg <= 6'h00;
      o_mic_bit_clock <= 1'b0;
    end else begin
      bclk_cnt_reg <= rise_en ? 6'h00 : bclk_cnt_reg + 6'h01;
      if (rise_en) begin
        o_mic_bit_clock <= 1'b1;
      end else if (fall_en) begin
        o_mic_bit_clock <= 1'b0;
      end
    end
  end
  // data is sampled in the cycle its edge is launched
  assign l_en = edge_reg ? rise_en : fall_en;
  assign r_en = edge_reg ? fall_en : rise_en;
  assign chan_clr = !running;

  dmi_chan u_left (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_clr(chan_clr), .i_bit_en(l_en),
    .i_bit(i_mic_data), .i_gain(left_gain_adjust_reg), .o_valid(l_valid), .o_pcm(l_pcm)
  );
  dmi_chan u_right (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_clr(chan_clr), .i_bit_en(r_en),
    .i_bit(i_mic_data), .i_gain(right_gain_adjust_reg), .o_valid(r_valid), .o_pcm(r_pcm)
  );

  // word packing: earlier sample in the low half
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      half_reg <= 1'b0;
      held_reg <= 16'h0000;
    end else if (!running) begin
      half_reg <= 1'b0;
    end else if (l_valid) begin
      held_reg <= l_pcm;
      half_reg <= mono_reg ? !half_reg : 1'b1;
    end else if (r_valid && !mono_reg) begin
      half_reg <= 1'b0;
    end
  end
  always_comb begin
    word_rdy = 1'b0;
    word = {r_pcm, held_reg};
    if (mono_reg) begin
      word_rdy = l_valid && half_reg;
      word = {l_pcm, held_reg};
    end else begin
      word_rdy = r_valid && half_reg;
    end
  end

  // dma writer and buffer bookkeeping
  assign dma_done = o_dma_valid && i_dma_ready;
  assign buf_full = dma_done
    && (samples_reg + 16'd2 >= {1'b0, maxcnt_reg});
  assign end_set = buf_full || stopped_set;
  assign started_set = (start_task && state_reg == DMI_IDLE && enable_reg)
    || (buf_full && state_reg == DMI_RUN);
  assign stopped_set = state_reg == DMI_DRAIN && !o_dma_valid && !half_reg
    && !word_rdy;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dma_valid <= 1'b0;
      o_dma_word <= '0;
    end else if (word_rdy && !o_dma_valid) begin
      o_dma_valid <= 1'b1;
      o_dma_word.addr <= wr_addr_reg;
      o_dma_word.data <= word;
    end else if (dma_done) begin
      o_dma_valid <= 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_addr_reg <= 32'h00000000;
      samples_reg <= '0;
    end else if (started_set) begin
      wr_addr_reg <= ptr_reg;
      samples_reg <= '0;
    end else if (dma_done) begin
      wr_addr_reg <= wr_addr_reg + 32'h4;
      samples_reg <= samples_reg + 16'd2;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= DMI_IDLE;
    end else begin
      unique case (state_reg)
        DMI_IDLE: if (started_set) state_reg <= DMI_RUN;
        DMI_RUN: if (stop_task || !enable_reg) state_reg <= DMI_DRAIN;
        DMI_DRAIN: if (stopped_set) state_reg <= DMI_IDLE;
        default: state_reg <= DMI_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [6:0] gap_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_reg <= 7'h00;
    end else begin
      gap_reg <= (rise_en || !running) ? 7'h01 : gap_reg + 7'h01;
    end
  end
  bclk_period_a: assert property (
    rise_en && $past(running) && $past(rise_en) == 1'b0 && gap_reg > 7'h02
    |-> gap_reg == {1'b0, div})
    else $error("bit clock period does not match divider");
  left_edge_a: assert property (
    l_en && !edge_reg |-> $past(o_mic_bit_clock) == 1'b1 && fall_en)
    else $error("left not sampled on falling edge by default");
  swap_edge_a: assert property (
    edge_reg && rise_en |-> l_en && !r_en && !o_mic_bit_clock)
    else $error("edge select does not swap channels");
  pack_low_a: assert property (
    word_rdy && !o_dma_valid |=> o_dma_word.data[15:0] == $past(held_reg))
    else $error("earlier sample not in low half");
  end_count_a: assert property (
    end_set && state_reg == DMI_RUN |=> ev_end_reg && samples_reg == '0)
    else $error("end event without buffer restart");
  restart_a: assert property (
    buf_full && state_reg == DMI_RUN |=> wr_addr_reg == $past(ptr_reg) && ev_started_reg)
    else $error("next buffer not taken from latched pointer");
  ptr_hold_a: assert property (
    wr && req_reg.ofs == `DMI_OFS_PTR && running && !started_set && !dma_done
    |=> $stable(wr_addr_reg))
    else $error("pointer write disturbed current buffer");
  stopped_a: assert property (
    $rose(ev_stopped_reg) |-> !$past(o_dma_valid) && state_reg == DMI_IDLE
    ##1 !o_mic_bit_clock [*2])
    else $error("stopped raised with activity left");
  start_a: assert property (
    start_task && state_reg == DMI_IDLE && enable_reg |=> state_reg == DMI_RUN && ev_started_reg)
    else $error("start task did not begin acquisition");
  stereo_word_c: cover property (word_rdy && !mono_reg);
  mono_word_c: cover property (word_rdy && mono_reg);
  buf_end_c: cover property (buf_full && state_reg == DMI_RUN);
  stop_c: cover property (stopped_set);
endmodule : dmi_top
`default_nettype wire

// ==== tb/dmi_mic_model.sv ====
// two microphones sharing one data line, left drives while the bit clock is high
// assumes: bit clock from the design, data sampled just before each clock edge
`default_nettype none
module dmi_mic_model (
  input wire logic i_bit_clock,
  output logic o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'b00;
  initial o_data = 1'b0;
  // left mic sends 1110 repeating (48 ones per 64), right mic sends zeros
  always @(i_bit_clock) begin
    if (i_bit_clock) begin
      phase <= phase + 2'd1;
      o_data <= #1 (phase != 2'b11);
    end else begin
      o_data <= #1 1'b0;
    end
  end
endmodule : dmi_mic_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench: ahb-lite register tasks, stalling dma sink, mic pair
// assumes: dmi_pkg, dmi_top and dmi_mic_model compiled before this file
`include "dmi_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb import dmi_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic dma_ready = 1'b0;
  logic prev_valid = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] ea;
  wire hready, hresp, bclk, mic, dma_valid;
  wire [31:0] hrdata;
  wire dmi_dma_word_t dma_word;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int rises[$];
  dmi_dma_word_t q[$];
  int divs[4] = '{32, 31, 30, 31};
  logic [31:0] codes[4] = '{`DMI_BIT_CLOCK_DIVIDER_SELECT_DIV32, `DMI_BIT_CLOCK_DIVIDER_SELECT_DIV31, `DMI_BIT_CLOCK_DIVIDER_SELECT_DIV30, 32'h0c000000};

  dmi_top dut (.i_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .o_mic_bit_clock(bclk),
    .i_mic_data(mic), .o_dma_valid(dma_valid), .o_dma_word(dma_word), .i_dma_ready(dma_ready));
  dmi_mic_model mics (.i_bit_clock(bclk), .o_data(mic));

  always #2.5 clk = ~clk;

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ram side stalls one cycle in three; also the run's cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    dma_ready <= (cyc % 3) != 0;
    prev_valid <= dma_valid;
    if (dma_valid === 1'b1 && prev_valid !== 1'b1) rises.push_back(cyc);
    if (dma_valid === 1'b1 && dma_ready === 1'b1) q.push_back(dma_word);
    if (cyc == 80000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= {20'h0, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("response", 1'b0, hresp)
  endtask : ahb

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, ofs, d, x);
  endtask : wr

  task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, ofs, 32'h0, x);
    `CHK($sformatf("register %h", ofs), e, x)
  endtask : rd_chk

  // polls an event flag until set, then clears it
  task automatic wait_ev(input logic [11:0] ofs);
    logic [31:0] x;
    x = 32'h0;
    while (x[0] !== 1'b1) ahb(1'b0, ofs, 32'h0, x);
    wr(ofs, 32'h0);
  endtask : wait_ev

  task automatic wait_words(input int n);
    while (q.size() < n) @(posedge clk);
  endtask : wait_words

  task automatic meas(input int div);
    realtime t0, t1, t2;
    @(posedge bclk);
    t0 = $realtime;
    @(negedge bclk);
    t1 = $realtime;
    @(posedge bclk);
    t2 = $realtime;
    `CHK("bit clock period", div, int'((t2 - t0) / 5.0))
    `CHK("bit clock high time", div / 2, int'((t1 - t0) / 5.0))
  endtask : meas

  task automatic run(input logic [31:0] mode, input logic [31:0] ptr, input logic [31:0] cnt);
    wr(`DMI_OFS_MODE, mode);
    wr(`DMI_OFS_PTR, ptr);
    wr(`DMI_OFS_MAXCNT, cnt);
    wr(`DMI_OFS_EV_END, 32'h0);
    rd_chk(`DMI_OFS_EV_END, 32'h0);
    wr(`DMI_OFS_EV_STARTED, 32'h0);
    q.delete();
    rises.delete();
    wr(`DMI_OFS_TASK_START, 32'h1);
    wait_ev(`DMI_OFS_EV_STARTED);
  endtask : run

  task automatic halt;
    wr(`DMI_OFS_TASK_STOP, 32'h1);
    wait_ev(`DMI_OFS_EV_STOPPED);
    `CHK("dma request after stop", 1'b0, dma_valid)
    `CHK("bit clock after stop", 1'b0, bclk)
  endtask : halt

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(`DMI_OFS_CLKCTRL, `DMI_CLKCTRL_RST);
    rd_chk(`DMI_OFS_LEFT_GAIN_ADJUST, 32'h28);
    rd_chk(`DMI_OFS_RIGHT_GAIN_ADJUST, 32'h28);
    rd_chk(`DMI_OFS_MODE, 32'h0);
    rd_chk(`DMI_OFS_PTR, 32'h0);
    rd_chk(`DMI_OFS_EV_STOPPED, 32'h0);
    rd_chk(12'h600, 32'h0);
    wr(`DMI_OFS_MAXCNT, 32'hffffffff);
    rd_chk(`DMI_OFS_MAXCNT, 32'h00007fff);
    wr(`DMI_OFS_LEFT_GAIN_ADJUST, 32'h50);
    rd_chk(`DMI_OFS_LEFT_GAIN_ADJUST, 32'h50);
    // byte-sized write is ignored
    hsize <= 3'b000;
    wr(`DMI_OFS_RIGHT_GAIN_ADJUST, 32'h11);
    hsize <= 3'b010;
    rd_chk(`DMI_OFS_RIGHT_GAIN_ADJUST, 32'h28);
    wr(`DMI_OFS_ENABLE, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`DMI_OFS_CLKCTRL, codes[i]);
      wr(`DMI_OFS_TASK_START, 32'h1);
      meas(divs[i]);
      halt();
    end
    // start refused while disabled; disabling a run stops it
    wr(`DMI_OFS_ENABLE, 32'h0);
    wr(`DMI_OFS_TASK_START, 32'h1);
    repeat (40) @(posedge clk);
    `CHK("bit clock while disabled", 1'b0, bclk)
    wr(`DMI_OFS_ENABLE, 32'h1);
    wr(`DMI_OFS_TASK_START, 32'h1);
    wr(`DMI_OFS_ENABLE, 32'h0);
    wait_ev(`DMI_OFS_EV_STOPPED);
    `CHK("bit clock after disable", 1'b0, bclk)
    wr(`DMI_OFS_ENABLE, 32'h1);
    // stereo: left 48/64 ones at 0 dB, right all zeros at -6 dB
    wr(`DMI_OFS_CLKCTRL, `DMI_BIT_CLOCK_DIVIDER_SELECT_DIV31);
    wr(`DMI_OFS_LEFT_GAIN_ADJUST, 32'h28);
    wr(`DMI_OFS_RIGHT_GAIN_ADJUST, 32'h1c);
    run(32'h0, 32'h20000000, 32'h4);
    wr(`DMI_OFS_PTR, 32'h20000400);
    wait_words(1);
    rd_chk(`DMI_OFS_EV_END, 32'h0);
    wait_words(2);
    rd_chk(`DMI_OFS_EV_END, 32'h1);
    rd_chk(`DMI_OFS_EV_STARTED, 32'h1);
    wait_words(4);
    halt();
    for (int i = 0; i < 4; i++) begin
      ea = (i < 2) ? 32'h20000000 : 32'h20000400;
      `CHK("stereo address", ea + 32'(4 * (i % 2)), q[i].addr)
    end
    // first word skipped while the filter settles
    for (int i = 1; i < 4; i++) `CHK("stereo word", 32'hc0004000, q[i].data)
    `CHK("stereo word spacing", 64 * 31, rises[2] - rises[1])
    // mono with swapped edges: left now carries the zero stream at -6 dB
    wr(`DMI_OFS_LEFT_GAIN_ADJUST, 32'h1c);
    run(32'h3, 32'h20000800, 32'h5);
    wait_words(2);
    rd_chk(`DMI_OFS_EV_END, 32'h0);
    wait_words(4);
    rd_chk(`DMI_OFS_EV_END, 32'h1);
    halt();
    for (int i = 0; i < 4; i++) `CHK("mono address", 32'h20000800 + 32'(4 * (i % 3)), q[i].addr)
    for (int i = 1; i < 4; i++) `CHK("mono word", 32'hc000c000, q[i].data)
    `CHK("mono word spacing", 128 * 31, rises[2] - rises[1])
    print_verdict();
  end
endmodule : tb
`default_nettype wire
